// file: hdl/pcx_params.svh
/*
 * Constants of the priority crossbar pin mux: register addresses, reset values,
 * bit positions and pin counts. Assumes inclusion by the decoder and crossbar modules.
 */
`ifndef PCX_PARAMS_SVH
`define PCX_PARAMS_SVH

`define PCX_NUM_PINS      25
`define PCX_POOL_PINS     20
`define PCX_NUM_FUNCS     21
`define PCX_UART_TX_PIN   4
`define PCX_UART_RX_PIN   5

`define PCX_ADDR_ROUTE0   8'he1
`define PCX_ADDR_ROUTE1   8'he2
`define PCX_ADDR_LATCH0   8'h80
`define PCX_ADDR_LATCH1   8'h90
`define PCX_ADDR_LATCH2   8'ha0
`define PCX_ADDR_LATCH3   8'hb0
`define PCX_ADDR_INMODE0  8'hf1
`define PCX_ADDR_INMODE1  8'hf2
`define PCX_ADDR_INMODE2  8'hf3
`define PCX_ADDR_INMODE3  8'hf4
`define PCX_ADDR_OUTMODE0 8'ha4
`define PCX_ADDR_OUTMODE1 8'ha5
`define PCX_ADDR_OUTMODE2 8'ha6
`define PCX_ADDR_OUTMODE3 8'ha7
`define PCX_ADDR_SKIP0    8'hd4
`define PCX_ADDR_SKIP1    8'hd5
`define PCX_ADDR_SKIP2    8'hd6

`define PCX_RST_ROUTE     8'h00
`define PCX_RST_LATCH     32'hffffffff
`define PCX_RST_INMODE    32'hffffffff
`define PCX_RST_OUTMODE   32'h00000000
`define PCX_RST_SKIP      24'h000000

`define PCX_R0_UART       0
`define PCX_R0_SPI        1
`define PCX_R0_SMBUS      2
`define PCX_R0_SYSCLK     3
`define PCX_R0_CMP0       4
`define PCX_R0_CP0A       5
`define PCX_R0_CMP1       6
`define PCX_R0_CP1A       7
`define PCX_R1_PCA_LSB    0
`define PCX_R1_PCNT       3
`define PCX_R1_T0         4
`define PCX_R1_T1         5
`define PCX_R1_XBAR_EN    6
`define PCX_R1_PU_DIS     7
`define PCX_PCA_MAX       3'h5

`endif

// file: hdl/pcx_pkg.sv
/*
 * Types of the priority crossbar pin mux: the function codes in priority order.
 * Assumes pcx_params.svh for the counts.
 */
package pcx_pkg;
   // priority order; code equals index into the function vectors
   typedef enum logic [4:0] {
      PCX_F_TX   = 5'h00, PCX_F_RX   = 5'h01, PCX_F_SCK  = 5'h02, PCX_F_MISO = 5'h03,
      PCX_F_MOSI = 5'h04, PCX_F_SSEL = 5'h05, PCX_F_SDA  = 5'h06, PCX_F_SCL  = 5'h07,
      PCX_F_CMP0 = 5'h08, PCX_F_CP0A = 5'h09, PCX_F_CMP1 = 5'h0a, PCX_F_CP1A = 5'h0b,
      PCX_F_SYSC = 5'h0c, PCX_F_PCA0 = 5'h0d, PCX_F_PCA1 = 5'h0e, PCX_F_PCA2 = 5'h0f,
      PCX_F_PCA3 = 5'h10, PCX_F_PCA4 = 5'h11, PCX_F_PCNT = 5'h12, PCX_F_T0   = 5'h13,
      PCX_F_T1   = 5'h14
   } pcx_func_e;
   typedef logic [4:0] pcx_func_t;
endpackage : pcx_pkg

// file: hdl/pcx_priority_decoder.sv
/*
 * Combinational priority decoder: places enabled functions onto pool pins.
 * Assumes function enables already qualified (slave select mode, PCA count).
 */
`timescale 1ns/1ps
`include "pcx_params.svh"
module pcx_priority_decoder
   import pcx_pkg::*;
#(
   parameter int POOL  = `PCX_POOL_PINS,
   parameter int NFUNC = `PCX_NUM_FUNCS
) (
   input  wire logic [NFUNC-1:0]           funcEn,
   input  wire logic [POOL-1:0]            skipBits,
   output logic      [POOL-1:0]            pinValid,
   output pcx_func_t [POOL-1:0]            pinFunc
);
   // uart first at fixed pins, then a lowest-free-pin scan per function
   always_comb begin
      logic [POOL-1:0] taken;
      logic            found;
      taken    = skipBits;
      found    = 1'b0;
      pinValid = '0;
      pinFunc  = '0;
      if (funcEn[PCX_F_TX]) begin
         pinValid[`PCX_UART_TX_PIN] = 1'b1;
         pinFunc[`PCX_UART_TX_PIN]  = PCX_F_TX;
         pinValid[`PCX_UART_RX_PIN] = 1'b1;
         pinFunc[`PCX_UART_RX_PIN]  = PCX_F_RX;
         taken[`PCX_UART_TX_PIN]    = 1'b1;
         taken[`PCX_UART_RX_PIN]    = 1'b1;
      end
      for (int f = 2; f < NFUNC; f++) begin
         found = 1'b0;
         if (funcEn[f]) begin
            for (int p = 0; p < POOL; p++) begin
               if (!found && !taken[p]) begin
                  pinValid[p] = 1'b1;
                  pinFunc[p]  = pcx_func_t'(f);
                  taken[p]    = 1'b1;
                  found       = 1'b1;
               end
            end
         end
      end
   end
endmodule : pcx_priority_decoder

// file: hdl/pcx_pin_cell.sv
/*
 * One port pin cell: driver level, driver enable and weak pull-up.
 * Assumes the caller registers the results before they leave the block.
 */
`timescale 1ns/1ps
module pcx_pin_cell #(
   parameter bit IN_POOL = 1'b1
) (
   input  wire logic xbarEnable,
   input  wire logic digitalMode,
   input  wire logic pushPull,
   input  wire logic forceOpenDrain,
   input  wire logic routed,
   input  wire logic funcData,
   input  wire logic funcDrive,
   input  wire logic latchBit,
   input  wire logic pullupDisable,
   output logic      driveLevel,
   output logic      driveEnable,
   output logic      pullupEnable
);
   logic active;
   logic data;
   logic want;
   logic openDrain;

   // pool pins only drive with the crossbar on; fixed gpio always may
   assign active    = IN_POOL ? xbarEnable : 1'b1;
   assign data      = routed ? funcData : latchBit;
   assign want      = routed ? funcDrive : 1'b1;
   assign openDrain = ~pushPull | forceOpenDrain;
   // open-drain only ever pulls low; high is left to the pull-up
   assign driveEnable  = active & digitalMode & want & (openDrain ? ~data : 1'b1);
   assign driveLevel   = openDrain ? 1'b0 : data;
   // no pull-up while sinking current, saves static power
   assign pullupEnable = digitalMode & openDrain & ~pullupDisable &
                         ~(driveEnable & ~driveLevel);
endmodule : pcx_pin_cell

// file: hdl/pcx_crossbar.sv
/*
 * Priority crossbar pin mux top: special function registers, routing of
 * peripheral signals onto port pins and the registered pin controls.
 * Assumes a single-cycle register port from the core, pad inputs synchronous
 * to clk, and a pad ring that resolves padOut/padOe/padPullup onto the wires.
 */
`timescale 1ns/1ps
`include "pcx_params.svh"
module pcx_crossbar
   import pcx_pkg::*;
#(
   parameter int NPINS = `PCX_NUM_PINS,
   parameter int POOL  = `PCX_POOL_PINS,
   parameter int NFUNC = `PCX_NUM_FUNCS
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic [7:0]        sfrAddr,
   input  wire logic              sfrWrite,
   input  wire logic [7:0]        sfrWrData,
   output logic      [7:0]        sfrRdData,
   input  wire logic [1:0]        slaveSelectModeBits,
   input  wire logic [NFUNC-1:0]  funcOut,
   input  wire logic [NFUNC-1:0]  funcDrive,
   output logic      [NFUNC-1:0]  funcIn,
   input  wire logic [NPINS-1:0]  padIn,
   output logic      [NPINS-1:0]  padOut,
   output logic      [NPINS-1:0]  padOe,
   output logic      [NPINS-1:0]  padPullup,
   output logic      [NPINS-1:0]  padRecvEn
);
   logic [7:0]       routeEnable0_reg;
   logic [7:0]       routeEnable1_reg;
   logic [31:0]      portLatch_reg;
   logic [31:0]      inMode_reg;
   logic [31:0]      outMode_reg;
   logic [23:0]      skip_reg;
   logic [7:0]       sfrRdData_reg;
   logic [7:0]       sfrRdData_next;
   logic [NPINS-1:0] padOut_reg;
   logic [NPINS-1:0] padOe_reg;
   logic [NPINS-1:0] padPullup_reg;
   logic [NPINS-1:0] padRecvEn_reg;
   logic [NFUNC-1:0] funcIn_reg;
   logic [NFUNC-1:0] funcIn_next;

   logic [NFUNC-1:0] funcEn;
   logic [POOL-1:0]  pinValid;
   pcx_func_t [POOL-1:0] pinFunc;
   logic [NPINS-1:0] pinRouted;
   logic [NPINS-1:0] pinFuncData;
   logic [NPINS-1:0] pinFuncDrive;
   logic [NPINS-1:0] pinSmbus;
   logic [NPINS-1:0] cellLevel;
   logic [NPINS-1:0] cellEnable;
   logic [NPINS-1:0] cellPullup;
   logic [NPINS-1:0] digitalMode;
   logic [NPINS-1:0] pushPullMode;
   logic [NPINS-1:0] latchBits;
   logic [NPINS-1:0] pinLevel;
   logic [2:0]       pcaCount;
   logic             xbarEnable;
   logic             pullupDisable;
   logic             fourWire;
   logic             ssPlaced;
   logic             pcaPlaced;

   // P3.0 lives at bit 24 of the flat port vectors
   assign digitalMode  = inMode_reg[NPINS-1:0];
   assign pushPullMode = outMode_reg[NPINS-1:0];
   assign latchBits    = portLatch_reg[NPINS-1:0];
   assign pinLevel     = padIn & digitalMode;
   assign xbarEnable   = routeEnable1_reg[`PCX_R1_XBAR_EN];
   assign pullupDisable = routeEnable1_reg[`PCX_R1_PU_DIS];
   assign pcaCount     = routeEnable1_reg[`PCX_R1_PCA_LSB +: 3];
   assign fourWire     = |slaveSelectModeBits;

   // routing register writes
   always_ff @(posedge clk) begin
      if (!rstn) begin
         routeEnable0_reg <= `PCX_RST_ROUTE;
         routeEnable1_reg <= `PCX_RST_ROUTE;
      end else if (sfrWrite) begin
         case (sfrAddr)
            `PCX_ADDR_ROUTE0: routeEnable0_reg <= sfrWrData;
            `PCX_ADDR_ROUTE1: routeEnable1_reg <= sfrWrData;
            default: ;
         endcase
      end
   end

   // port latch writes; reset leaves every latch high
   always_ff @(posedge clk) begin
      if (!rstn) begin
         portLatch_reg <= `PCX_RST_LATCH;
      end else if (sfrWrite) begin
         case (sfrAddr)
            `PCX_ADDR_LATCH0: portLatch_reg[7:0]   <= sfrWrData;
            `PCX_ADDR_LATCH1: portLatch_reg[15:8]  <= sfrWrData;
            `PCX_ADDR_LATCH2: portLatch_reg[23:16] <= sfrWrData;
            `PCX_ADDR_LATCH3: portLatch_reg[31:24] <= sfrWrData;
            default: ;
         endcase
      end
   end

   // input and output mode writes
   always_ff @(posedge clk) begin
      if (!rstn) begin
         inMode_reg  <= `PCX_RST_INMODE;
         outMode_reg <= `PCX_RST_OUTMODE;
      end else if (sfrWrite) begin
         case (sfrAddr)
            `PCX_ADDR_INMODE0:  inMode_reg[7:0]    <= sfrWrData;
            `PCX_ADDR_INMODE1:  inMode_reg[15:8]   <= sfrWrData;
            `PCX_ADDR_INMODE2:  inMode_reg[23:16]  <= sfrWrData;
            `PCX_ADDR_INMODE3:  inMode_reg[31:24]  <= sfrWrData;
            `PCX_ADDR_OUTMODE0: outMode_reg[7:0]   <= sfrWrData;
            `PCX_ADDR_OUTMODE1: outMode_reg[15:8]  <= sfrWrData;
            `PCX_ADDR_OUTMODE2: outMode_reg[23:16] <= sfrWrData;
            `PCX_ADDR_OUTMODE3: outMode_reg[31:24] <= sfrWrData;
            default: ;
         endcase
      end
   end

   // skip writes; only the pool pins have skip bits that matter
   always_ff @(posedge clk) begin
      if (!rstn) begin
         skip_reg <= `PCX_RST_SKIP;
      end else if (sfrWrite) begin
         case (sfrAddr)
            `PCX_ADDR_SKIP0: skip_reg[7:0]   <= sfrWrData;
            `PCX_ADDR_SKIP1: skip_reg[15:8]  <= sfrWrData;
            `PCX_ADDR_SKIP2: skip_reg[23:16] <= sfrWrData;
            default: ;
         endcase
      end
   end

   // read mux; latch addresses return pin levels, analog pins read zero
   always_comb begin
      case (sfrAddr)
         `PCX_ADDR_ROUTE0:   sfrRdData_next = routeEnable0_reg;
         `PCX_ADDR_ROUTE1:   sfrRdData_next = routeEnable1_reg;
         `PCX_ADDR_LATCH0:   sfrRdData_next = pinLevel[7:0];
         `PCX_ADDR_LATCH1:   sfrRdData_next = pinLevel[15:8];
         `PCX_ADDR_LATCH2:   sfrRdData_next = pinLevel[23:16];
         `PCX_ADDR_LATCH3:   sfrRdData_next = {7'h00, pinLevel[24]};
         `PCX_ADDR_INMODE0:  sfrRdData_next = inMode_reg[7:0];
         `PCX_ADDR_INMODE1:  sfrRdData_next = inMode_reg[15:8];
         `PCX_ADDR_INMODE2:  sfrRdData_next = inMode_reg[23:16];
         `PCX_ADDR_INMODE3:  sfrRdData_next = inMode_reg[31:24];
         `PCX_ADDR_OUTMODE0: sfrRdData_next = outMode_reg[7:0];
         `PCX_ADDR_OUTMODE1: sfrRdData_next = outMode_reg[15:8];
         `PCX_ADDR_OUTMODE2: sfrRdData_next = outMode_reg[23:16];
         `PCX_ADDR_OUTMODE3: sfrRdData_next = outMode_reg[31:24];
         `PCX_ADDR_SKIP0:    sfrRdData_next = skip_reg[7:0];
         `PCX_ADDR_SKIP1:    sfrRdData_next = skip_reg[15:8];
         `PCX_ADDR_SKIP2:    sfrRdData_next = skip_reg[23:16];
         default:            sfrRdData_next = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sfrRdData_reg <= 8'h00;
      end else begin
         sfrRdData_reg <= sfrRdData_next;
      end
   end

   // function enables in priority order; reserved pca codes route nothing
   always_comb begin
      funcEn             = '0;
      funcEn[PCX_F_TX]   = routeEnable0_reg[`PCX_R0_UART];
      funcEn[PCX_F_RX]   = routeEnable0_reg[`PCX_R0_UART];
      funcEn[PCX_F_SCK]  = routeEnable0_reg[`PCX_R0_SPI];
      funcEn[PCX_F_MISO] = routeEnable0_reg[`PCX_R0_SPI];
      funcEn[PCX_F_MOSI] = routeEnable0_reg[`PCX_R0_SPI];
      funcEn[PCX_F_SSEL] = routeEnable0_reg[`PCX_R0_SPI] & fourWire;
      funcEn[PCX_F_SDA]  = routeEnable0_reg[`PCX_R0_SMBUS];
      funcEn[PCX_F_SCL]  = routeEnable0_reg[`PCX_R0_SMBUS];
      funcEn[PCX_F_CMP0] = routeEnable0_reg[`PCX_R0_CMP0];
      funcEn[PCX_F_CP0A] = routeEnable0_reg[`PCX_R0_CP0A];
      funcEn[PCX_F_CMP1] = routeEnable0_reg[`PCX_R0_CMP1];
      funcEn[PCX_F_CP1A] = routeEnable0_reg[`PCX_R0_CP1A];
      funcEn[PCX_F_SYSC] = routeEnable0_reg[`PCX_R0_SYSCLK];
      for (int k = 0; k < 5; k++) begin
         funcEn[PCX_F_PCA0 + k] = (pcaCount <= `PCX_PCA_MAX) && (pcaCount > 3'(k));
      end
      funcEn[PCX_F_PCNT] = routeEnable1_reg[`PCX_R1_PCNT];
      funcEn[PCX_F_T0]   = routeEnable1_reg[`PCX_R1_T0];
      funcEn[PCX_F_T1]   = routeEnable1_reg[`PCX_R1_T1];
   end

   pcx_priority_decoder #(
      .POOL  (POOL),
      .NFUNC (NFUNC)
   ) u_decoder (
      .funcEn   (funcEn),
      .skipBits (skip_reg[POOL-1:0]),
      .pinValid (pinValid),
      .pinFunc  (pinFunc)
   );

   // per-pin selection of the routed peripheral signal
   always_comb begin
      pinRouted    = '0;
      pinFuncData  = '0;
      pinFuncDrive = '0;
      pinSmbus     = '0;
      ssPlaced     = 1'b0;
      pcaPlaced    = 1'b0;
      for (int p = 0; p < POOL; p++) begin
         pinRouted[p]    = pinValid[p];
         // placement flags feed only the checks at the bottom
         ssPlaced        = ssPlaced | (pinValid[p] && pinFunc[p] == PCX_F_SSEL);
         pcaPlaced       = pcaPlaced | (pinValid[p] && pinFunc[p] >= PCX_F_PCA0
                                        && pinFunc[p] <= PCX_F_PCA4);
         pinFuncData[p]  = funcOut[pinFunc[p]];
         pinFuncDrive[p] = funcDrive[pinFunc[p]];
         pinSmbus[p]     = pinValid[p] &&
                           (pinFunc[p] == PCX_F_SDA || pinFunc[p] == PCX_F_SCL);
      end
   end

   // one cell per pin; the top five pins never join the pool
   for (genvar g = 0; g < NPINS; g++) begin : g_cell
      pcx_pin_cell #(
         .IN_POOL (g < POOL)
      ) u_cell (
         .xbarEnable     (xbarEnable),
         .digitalMode    (digitalMode[g]),
         .pushPull       (pushPullMode[g]),
         .forceOpenDrain (pinSmbus[g] & xbarEnable),
         .routed         (pinRouted[g] & xbarEnable),
         .funcData       (pinFuncData[g]),
         .funcDrive      (pinFuncDrive[g]),
         .latchBit       (latchBits[g]),
         .pullupDisable  (pullupDisable),
         .driveLevel     (cellLevel[g]),
         .driveEnable    (cellEnable[g]),
         .pullupEnable   (cellPullup[g])
      );
   end

   // pin controls registered so the pad ring sees glitch-free enables
   always_ff @(posedge clk) begin
      if (!rstn) begin
         padOut_reg    <= '0;
         padOe_reg     <= '0;
         padPullup_reg <= '0;
         padRecvEn_reg <= '0;
      end else begin
         padOut_reg    <= cellLevel;
         padOe_reg     <= cellEnable;
         padPullup_reg <= cellPullup;
         padRecvEn_reg <= digitalMode;
      end
   end

   // inputs back to peripherals; unrouted inputs idle high like a released line
   always_comb begin
      funcIn_next = '1;
      for (int p = 0; p < POOL; p++) begin
         if (pinValid[p] && xbarEnable) begin
            funcIn_next[pinFunc[p]] = pinLevel[p];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         funcIn_reg <= '1;
      end else begin
         funcIn_reg <= funcIn_next;
      end
   end

   assign sfrRdData = sfrRdData_reg;
   assign padOut    = padOut_reg;
   assign padOe     = padOe_reg;
   assign padPullup = padPullup_reg;
   assign padRecvEn = padRecvEn_reg;
   assign funcIn    = funcIn_reg;

   // checks on the placement and the registered pin controls
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   AST_XBAR_OFF_QUIET: assert property (
      $past(rstn) && !$past(xbarEnable) |-> (padOe[POOL-1:0] == '0))
      else $error("pool pin driven while crossbar disabled");

   AST_UART_FIXED: assert property (
      funcEn[PCX_F_TX] |-> pinValid[`PCX_UART_TX_PIN] && pinFunc[`PCX_UART_TX_PIN] == PCX_F_TX
                          && pinValid[`PCX_UART_RX_PIN] && pinFunc[`PCX_UART_RX_PIN] == PCX_F_RX)
      else $error("uart not on its fixed pins");

   AST_SKIP_PASSED: assert property (
      ((skip_reg[POOL-1:0] & pinValid) & ~({POOL{funcEn[PCX_F_TX]}} & 20'h00030)) == '0)
      else $error("skipped pin was assigned");

   AST_ANALOG_QUIET: assert property (
      $past(rstn) |-> ((padOe | padPullup | padRecvEn) & ~$past(digitalMode)) == '0)
      else $error("analog pin has driver, pull-up or receiver on");

   AST_SMBUS_NEVER_HIGH: assert property (
      $past(rstn) |-> (padOe & padOut & $past(pinSmbus)) == '0)
      else $error("smbus pin driven high");

   AST_PULLUP_OFF_LOW: assert property (
      (padPullup & padOe & ~padOut) == '0)
      else $error("pull-up on while driving low");

   AST_PULLUP_DISABLED: assert property (
      $past(rstn) && $past(pullupDisable) |-> padPullup == '0)
      else $error("pull-up on while globally disabled");

   AST_FIXED_GPIO_DRIVE: assert property (
      $past(rstn) |-> ((padOe[NPINS-1:POOL] ^ $past(digitalMode[NPINS-1:POOL]
                        & (pushPullMode[NPINS-1:POOL] | ~latchBits[NPINS-1:POOL]))) == '0))
      else $error("fixed gpio pin drive does not follow its mode and latch");

   AST_SSEL_ONLY_4WIRE: assert property (
      !fourWire |-> !ssPlaced)
      else $error("slave select placed in 3-wire mode");

   AST_SMBUS_PAIR: assert property (
      funcEn[PCX_F_SDA] && pinValid[0] && pinFunc[0] == PCX_F_SDA && !skip_reg[1]
      |-> pinValid[1] && pinFunc[1] == PCX_F_SCL)
      else $error("smbus pins not consecutive");

   AST_PCA_CODE_ROUTE: assert property (
      (pcaCount == 3'h0 || pcaCount > `PCX_PCA_MAX) |-> !pcaPlaced)
      else $error("pca output placed for an empty or reserved count");

   AST_FUNCIN_IDLE: assert property (
      $past(rstn) && !$past(xbarEnable) |-> funcIn == '1)
      else $error("peripheral input not idle while crossbar disabled");

   COV_UART_LIVE:  cover property (xbarEnable && funcEn[PCX_F_TX] ##1 padOe[`PCX_UART_TX_PIN]);
   COV_SMBUS_LIVE: cover property (xbarEnable && |pinSmbus);
   COV_POOL_FULL:  cover property (xbarEnable && (&pinValid));
   COV_PCA_FIVE:   cover property (funcEn[PCX_F_PCA4] && |pinValid);
endmodule : pcx_crossbar

// file: test/pcx_ext_circuit.sv
/* external circuits on the pads: each pad resolved from driver and pull-up.
   assumes registered pad controls from the crossbar. */
`timescale 1ns/1ps
module pcx_ext_circuit (
   input  wire logic        clk,
   input  wire logic [24:0] padOut,
   input  wire logic [24:0] padOe,
   input  wire logic [24:0] padPullup,
   output logic      [24:0] padIn
);
   logic [24:0] float_reg = 25'h0aaaaaa;
   // floating pads toggle so a stale level never passes for a real one
   always @(posedge clk) float_reg <= ~float_reg;
   // driver wins, then pull-up, then floating pattern
   assign padIn = (padOe & padOut) | (~padOe & (padPullup | float_reg));
endmodule : pcx_ext_circuit

// file: test/tb_priority_crossbar_pin_mux.sv
/* self-checking bench of the crossbar: random configurations checked against
   its own placement model. assumes pcx_crossbar and pcx_ext_circuit. */
`timescale 1ns/1ps
module tb_priority_crossbar_pin_mux;
   import pcx_pkg::*;
   typedef struct {int kind; logic [24:0] exp, mask; int due;} pcx_note_s;
   logic        clk = 1'b0, rstn = 1'b0, sfrWrite = 1'b0;
   logic [7:0]  sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData, r0, r1;
   logic [1:0]  slaveSelectModeBits = 2'h0;
   logic [20:0] funcOut = '0, funcDrive = '1, funcIn;
   logic [24:0] padIn, padOut, padOe, padPullup, padRecvEn, inm, outm, lat;
   logic [19:0] sk;
   int          miscompares = 0, samples_checked = 0, cyc = 0, seed = 32'h6b3c;
   int          fnAt[20];
   pcx_note_s   notes[$];
   localparam logic [7:0] ADDRS[17] = '{8'h80, 8'h90, 8'ha0, 8'hb0, 8'hf1, 8'hf2, 8'hf3, 8'hf4,
      8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'hd4, 8'hd5, 8'hd6, 8'he1, 8'he2};
   pcx_crossbar dut (.clk(clk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWrData(sfrWrData),
      .sfrRdData(sfrRdData), .slaveSelectModeBits(slaveSelectModeBits), .funcOut(funcOut),
      .funcDrive(funcDrive), .funcIn(funcIn), .padIn(padIn), .padOut(padOut), .padOe(padOe),
      .padPullup(padPullup), .padRecvEn(padRecvEn));
   pcx_ext_circuit ext (.clk(clk), .padOut(padOut), .padOe(padOe), .padPullup(padPullup), .padIn(padIn));
   // free-running clock and cycle count for due dates
   initial forever #4 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   task automatic cmpReg(input logic [7:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: register read %h expected %h", $time, got, exp);
      end
   endtask : cmpReg
   task automatic cmpPins(input int kind, input logic [24:0] got, exp, mask);
      samples_checked++;
      if ((got & mask) !== (exp & mask)) begin
         miscompares++;
         $display("mismatch at %0t: pin vector %0d got %h expected %h", $time, kind, got & mask, exp & mask);
      end
   endtask : cmpPins
   // watcher: oldest note is compared once its result is due
   always @(negedge clk) begin
      while (notes.size() > 0 && notes[0].due <= cyc) begin
         if (notes[0].kind == 0) cmpReg(sfrRdData, notes[0].exp[7:0]);
         else cmpPins(notes[0].kind, notes[0].kind == 1 ? padOe : notes[0].kind == 2 ? padOut :
            notes[0].kind == 3 ? padPullup : notes[0].kind == 4 ? padRecvEn : {4'h0, funcIn},
            notes[0].exp, notes[0].mask);
         void'(notes.pop_front());
      end
   end
   task automatic note(input int k, input logic [24:0] e, m);
      notes.push_back('{k, e, m, cyc + 1});
   endtask : note
   task automatic wr(input logic [7:0] a, d);
      sfrAddr <= a;
      sfrWrite <= 1'b1;
      sfrWrData <= d;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, e);
      sfrAddr <= a;
      sfrWrite <= 1'b0;
      // read data is registered one edge after the address is taken
      notes.push_back('{0, {17'h0, e}, '1, cyc + 2});
      @(posedge clk);
   endtask : rd
   // own placement model: uart fixed, then lowest free unskipped pool pin
   function automatic void place();
      logic [20:0] en;
      logic [19:0] used;
      int p;
      en = '0;
      en[4:0] = {{3{r0[1]}}, {2{r0[0]}}};
      en[5] = r0[1] & (slaveSelectModeBits != 2'h0);
      en[12:6] = {r0[3], r0[7:4], {2{r0[2]}}};
      for (int k = 0; k < 5; k++) en[13 + k] = k < r1[2:0] && r1[2:0] < 3'h6;
      en[20:18] = r1[5:3];
      used = sk;
      for (int i = 0; i < 20; i++) fnAt[i] = -1;
      if (r0[0]) begin
         used[5:4] = 2'h3;
         fnAt[4] = 0;
         fnAt[5] = 1;
      end
      for (int f = 2; f < 21; f++) if (en[f]) begin
         p = 0;
         while (p < 20 && used[p]) p++;
         if (p < 20) begin
            used[p] = 1'b1;
            fnAt[p] = f;
         end
      end
   endfunction : place
   task automatic expPins();
      logic [24:0] oe, out, pu, fi, fm;
      logic d, od, w, rt;
      place();
      fi = 25'h01fffff;
      fm = '1;
      for (int p = 0; p < 25; p++) begin
         rt = p < 20 && fnAt[p] >= 0 && r1[6];
         d = rt ? funcOut[fnAt[p]] : lat[p];
         w = rt ? funcDrive[fnAt[p]] : 1'b1;
         od = ~outm[p] | (rt && fnAt[p] inside {6, 7});
         oe[p] = inm[p] & (p > 19 | r1[6]) & w & (od ? ~d : 1'b1);
         out[p] = ~od & d;
         pu[p] = inm[p] & od & ~r1[7] & ~oe[p];
         // floating pads carry no known level, so only driven, pulled or analog pins count
         if (rt) begin
            fi[fnAt[p]] = inm[p] & (~oe[p] | out[p]);
            fm[fnAt[p]] = ~inm[p] | oe[p] | pu[p];
         end
      end
      note(5, fi, fm);
      note(1, oe, '1);
      note(2, out, oe);
      note(3, pu, '1);
      note(4, inm, '1);
   endtask : expPins
   // random configuration written in the documented order
   task automatic cfg(input logic xe, input logic [2:0] pca);
      logic [7:0] t[17];
      inm = 25'($random(seed));
      outm = 25'($random(seed));
      lat = 25'($random(seed));
      sk = 20'($random(seed)) | ~inm[19:0];
      r0 = 8'($random(seed));
      r1 = {8'($random(seed)) & 8'hb8} | {1'b0, xe, 3'h0, pca};
      funcOut <= 21'($random(seed));
      funcDrive <= 21'($random(seed));
      slaveSelectModeBits <= 2'($random(seed));
      t = '{lat[7:0], lat[15:8], lat[23:16], {7'h0, lat[24]}, inm[7:0], inm[15:8], inm[23:16], {7'h0, inm[24]},
         outm[7:0], outm[15:8], outm[23:16], {7'h0, outm[24]}, sk[7:0], sk[15:8], {4'h0, sk[19:16]}, r0, r1 & 8'hbf};
      for (int i = 0; i < 17; i++) wr(ADDRS[i], t[i]);
      wr(8'he2, r1);
      sfrWrite <= 1'b0;
      repeat (3) @(posedge clk);
      expPins();
      rd(8'he1, r0);
      rd(8'he2, r1);
   endtask : cfg
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
   // main sequence: reset values, crossbar off, then every pca code
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      {r0, r1, outm, sk, inm, lat} = {16'h0, 45'h0, 50'h3ffffffffffff};
      repeat (3) @(posedge clk);
      expPins();
      foreach (ADDRS[i]) rd(ADDRS[i], i == 3 ? 8'h01 : i < 8 ? 8'hff : 8'h00);
      rd(8'h33, 8'h00);
      cfg(1'b0, 3'h5);
      for (int i = 0; i < 8; i++) cfg(1'b1, 3'(i));
      for (int i = 0; i < 10 && notes.size() > 0; i++) @(posedge clk);
      if (notes.size() > 0) miscompares++;
      give_verdict();
   end
endmodule : tb_priority_crossbar_pin_mux
